// File: core/fbk_pkg.sv
// package: shared types and constants for the flop bank
package fbk_pkg;

	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int FBK_WIDTH = 4;
	localparam logic FBK_TRUE_RST = 1'b0;
	localparam logic FBK_COMP_RST = 1'b1;
	localparam logic FBK_EDGE_RST = 1'b0;
	localparam logic FBK_FLAG_RST = 1'b0;
	localparam logic FBK_CLR_FORCE = 1'b0;
	localparam logic FBK_PRE_FORCE = 1'b1;

	// ----------------------------------------------------------------
	// both-active value settings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FBK_CPV_NONE,
		FBK_CPV_LOW,
		FBK_CPV_HIGH,
		FBK_CPV_HOLD,
		FBK_CPV_TOGGLE,
		FBK_CPV_UNKNOWN
	} fbk_cpv_e;

	// ----------------------------------------------------------------
	// next-value equation choices
	// ----------------------------------------------------------------
	typedef enum logic {
		FBK_NS_D,
		FBK_NS_JK
	} fbk_ns_e;

endpackage : fbk_pkg

// File: core/fbk_edge.sv
// module: active-edge detector for one cell clock expression
`timescale 1ns/1ns
`default_nettype none

module fbk_edge
	import fbk_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst_n,
	// watched clock expression
	input wire logic level,
	input wire logic inv,
	// active edge seen this cycle
	output logic edge_p
);

	typedef struct packed {
		logic prev;
	} fbk_edge_s;

	fbk_edge_s r;
	fbk_edge_s nxt;

	// remember last level so any change is noticed
	always_comb begin
		nxt = r;
		nxt.prev = level;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r.prev <= FBK_EDGE_RST;
		end else begin
			r <= nxt;
		end
	end

	// plain expression is rising, inverted expression is falling
	assign edge_p = inv ? (r.prev & ~level) : (~r.prev & level);

endmodule : fbk_edge

`default_nettype wire

// File: core/fbk_bit.sv
// module: one storage bit with true/complement, clear, preset, master-slave
`timescale 1ns/1ns
`default_nettype none

module fbk_bit
	import fbk_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst_n,
	// controls shared across the bank
	input wire logic master_slave,
	input wire logic edge_master,
	input wire logic edge_slave,
	input wire logic clr_act,
	input wire logic pre_act,
	input wire fbk_cpv_e cpv_true,
	input wire fbk_cpv_e cpv_comp,
	// per-bit next value
	input wire logic next_val,
	// visible state
	output logic true_q,
	output logic comp_q
);

	typedef struct packed {
		logic master_true_out;
		logic master_comp_out;
		logic true_state;
		logic complement_state;
	} fbk_bit_s;

	fbk_bit_s r;
	fbk_bit_s nxt;

	// both-active setting applied to a current value
	function automatic logic cpv_apply(input fbk_cpv_e v, input logic cur);
		logic res;
		res = cur;
		unique case (v)
			FBK_CPV_LOW: res = 1'b0;
			FBK_CPV_HIGH: res = 1'b1;
			FBK_CPV_HOLD: res = cur;
			FBK_CPV_TOGGLE: res = ~cur;
			FBK_CPV_UNKNOWN: res = 1'b0; // unknown resolves low, flagged above
			FBK_CPV_NONE: res = cur;
			default: res = cur;
		endcase
		return res;
	endfunction : cpv_apply

	// controls override clock edges; both-active takes the settings
	always_comb begin
		nxt = r;
		if (clr_act && pre_act) begin
			if (master_slave) begin
				nxt.master_true_out = cpv_apply(cpv_true, r.master_true_out);
				nxt.master_comp_out = cpv_apply(cpv_comp, r.master_comp_out);
				nxt.true_state = nxt.master_true_out;
				nxt.complement_state = nxt.master_comp_out;
			end else begin
				nxt.true_state = cpv_apply(cpv_true, r.true_state);
				nxt.complement_state = cpv_apply(cpv_comp, r.complement_state);
			end
		end else if (clr_act) begin
			nxt.master_true_out = FBK_CLR_FORCE;
			nxt.master_comp_out = ~FBK_CLR_FORCE;
			nxt.true_state = FBK_CLR_FORCE;
			nxt.complement_state = ~FBK_CLR_FORCE;
		end else if (pre_act) begin
			nxt.master_true_out = FBK_PRE_FORCE;
			nxt.master_comp_out = ~FBK_PRE_FORCE;
			nxt.true_state = FBK_PRE_FORCE;
			nxt.complement_state = ~FBK_PRE_FORCE;
		end else begin
			// slave copies the old master when both edges coincide
			if (master_slave && edge_slave) begin
				nxt.true_state = r.master_true_out;
				nxt.complement_state = r.master_comp_out;
			end
			if (edge_master) begin
				if (master_slave) begin
					nxt.master_true_out = next_val;
					nxt.master_comp_out = ~next_val;
				end else begin
					nxt.true_state = next_val;
					nxt.complement_state = ~next_val;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r.master_true_out <= FBK_TRUE_RST;
			r.master_comp_out <= FBK_COMP_RST;
			r.true_state <= FBK_TRUE_RST;
			r.complement_state <= FBK_COMP_RST;
		end else begin
			r <= nxt;
		end
	end

	assign true_q = r.true_state;
	assign comp_q = r.complement_state;

endmodule : fbk_bit

`default_nettype wire

// File: core/fbk_bank.sv
// module: parallel storage group top, bank of identical storage bits
`timescale 1ns/1ns
`default_nettype none

module fbk_bank
	import fbk_pkg::*;
#(
	parameter int WIDTH = FBK_WIDTH
) (
	// system
	input wire logic CLK,
	input wire logic RST_N,
	// configuration
	input wire logic CLR_EN,
	input wire logic CLR_ACT_HIGH,
	input wire logic PRE_EN,
	input wire logic PRE_ACT_HIGH,
	input wire fbk_cpv_e CPV_TRUE,
	input wire fbk_cpv_e CPV_COMP,
	input wire logic MASTER_SLAVE,
	input wire logic CLK_INV,
	input wire logic CLK_ALSO_INV,
	input wire fbk_ns_e NS_MODE,
	input wire logic SYNC_CLR_EN,
	// shared controls
	input wire logic CELL_CLK,
	input wire logic CELL_CLK_ALSO,
	input wire logic CLR_IN,
	input wire logic PRE_IN,
	input wire logic SYNC_CLR,
	// grouped data, one member per bit
	input wire logic [WIDTH-1:0] D,
	input wire logic [WIDTH-1:0] K,
	// visible states
	output logic [WIDTH-1:0] Q,
	output logic [WIDTH-1:0] QN,
	// status
	output logic CFG_ERR,
	output logic UNKNOWN_SEEN
);

	// ----------------------------------------------------------------
	// top-level state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cfg_err;
		logic unknown_seen;
	} fbk_top_s;

	fbk_top_s r;
	fbk_top_s nxt;

	logic clr_act;
	logic pre_act;
	logic both_act;
	logic edge_m;
	logic edge_s;
	logic edge_s_raw;
	logic cpv_t_set;
	logic cpv_c_set;
	logic cfg_bad;
	logic [WIDTH-1:0] ns_vec;
	logic [WIDTH-1:0] q_true;
	logic [WIDTH-1:0] q_comp;

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	// configured active levels; a disabled control never acts
	assign clr_act = CLR_EN && (CLR_IN == CLR_ACT_HIGH);
	assign pre_act = PRE_EN && (PRE_IN == PRE_ACT_HIGH);
	assign both_act = clr_act && pre_act;

	// setting presence and consistency check
	assign cpv_t_set = (CPV_TRUE != FBK_CPV_NONE);
	assign cpv_c_set = (CPV_COMP != FBK_CPV_NONE);
	assign cfg_bad = (CLR_EN && PRE_EN && !cpv_t_set && !cpv_c_set) ||
		((cpv_t_set || cpv_c_set) && !(CLR_EN && PRE_EN));

	// ----------------------------------------------------------------
	// clock edge detection
	// ----------------------------------------------------------------
	// each input is sampled every cycle, so any change is seen
	fbk_edge u_edge_master (
		.clk(CLK),
		.rst_n(RST_N),
		.level(CELL_CLK),
		.inv(CLK_INV),
		.edge_p(edge_m)
	);

	fbk_edge u_edge_slave (
		.clk(CLK),
		.rst_n(RST_N),
		.level(CELL_CLK_ALSO),
		.inv(CLK_ALSO_INV),
		.edge_p(edge_s_raw)
	);

	// second clock ignored in single-stage operation
	assign edge_s = MASTER_SLAVE && edge_s_raw;

	// ----------------------------------------------------------------
	// next-value equation
	// ----------------------------------------------------------------
	// only true state feeds back; complement is never read here
	always_comb begin
		if (NS_MODE == FBK_NS_JK) begin
			ns_vec = (D & ~q_true) | (~K & q_true);
		end else begin
			ns_vec = D;
		end
		if (SYNC_CLR_EN) begin
			ns_vec = ns_vec & {WIDTH{~SYNC_CLR}};
		end
	end

	// ----------------------------------------------------------------
	// the bank
	// ----------------------------------------------------------------
	// identical bits, shared controls fanned out to all
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		fbk_bit u_bit (
			.clk(CLK),
			.rst_n(RST_N),
			.master_slave(MASTER_SLAVE),
			.edge_master(edge_m),
			.edge_slave(edge_s),
			.clr_act(clr_act),
			.pre_act(pre_act),
			.cpv_true(CPV_TRUE),
			.cpv_comp(CPV_COMP),
			.next_val(ns_vec[i]),
			.true_q(q_true[i]),
			.comp_q(q_comp[i])
		);
	end

	// outputs straight from per-bit state flops
	assign Q = q_true;
	assign QN = q_comp;

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// unknown setting resolves to low; the flag lets software notice
	always_comb begin
		nxt = r;
		nxt.cfg_err = cfg_bad;
		if (both_act && (CPV_TRUE == FBK_CPV_UNKNOWN ||
			CPV_COMP == FBK_CPV_UNKNOWN)) begin
			nxt.unknown_seen = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			r.cfg_err <= FBK_FLAG_RST;
			r.unknown_seen <= FBK_FLAG_RST;
		end else begin
			r <= nxt;
		end
	end

	assign CFG_ERR = r.cfg_err;
	assign UNKNOWN_SEEN = r.unknown_seen;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	logic quiet;
	assign quiet = !clr_act && !pre_act;

	// single-stage loading from the equation
	load_true_a: assert property (
		!MASTER_SLAVE && edge_m && quiet |=>
		Q == $past(ns_vec) && QN == ~$past(ns_vec))
		else $error("bank did not load next value");

	// clear and preset act at the next edge whatever the cell clocks do
	clear_force_a: assert property (
		clr_act && !pre_act |=> Q == '0 && QN == '1)
		else $error("clear did not force states");

	preset_force_a: assert property (
		pre_act && !clr_act |=> Q == '1 && QN == '0)
		else $error("preset did not force states");

	// both active: each state follows its own setting
	both_low_high_a: assert property (
		both_act && CPV_TRUE == FBK_CPV_LOW && CPV_COMP == FBK_CPV_HIGH
		|=> Q == '0 && QN == '1)
		else $error("both-active settings not applied");

	both_toggle_a: assert property (
		!MASTER_SLAVE && both_act && CPV_TRUE == FBK_CPV_TOGGLE &&
		CPV_COMP == FBK_CPV_HOLD |=> Q == ~$past(Q) && QN == $past(QN))
		else $error("toggle or hold setting wrong");

	cfg_check_a: assert property (
		CLR_EN && !PRE_EN && cpv_t_set ##1 CLR_EN && !PRE_EN && cpv_t_set
		|=> CFG_ERR)
		else $error("configuration error not flagged");

	idle_hold_a: assert property (
		!edge_m && !edge_s && quiet |=> Q == $past(Q) && QN == $past(QN))
		else $error("state changed without a cause");

	// history register against the sampled pin, first cycle after reset skipped
	edge_sel_a: assert property (
		$past(RST_N) |-> edge_m == (CLK_INV ? $fell(CELL_CLK) : $rose(CELL_CLK)))
		else $error("wrong active clock edge");

	sync_clear_a: assert property (
		!MASTER_SLAVE && edge_m && quiet && SYNC_CLR_EN && SYNC_CLR
		|=> Q == '0 && QN == '1)
		else $error("synchronous clear not applied");

	single_stage_a: assert property (
		!MASTER_SLAVE && edge_s_raw && !edge_m && quiet
		|=> Q == $past(Q) && QN == $past(QN))
		else $error("second clock active in single stage");

	// master-slave: only the slave stage is visible
	master_hidden_a: assert property (
		MASTER_SLAVE && edge_m && !edge_s && quiet |=> Q == $past(Q))
		else $error("master edge reached visible state");

	ms_transfer_a: assert property (
		MASTER_SLAVE && edge_m && quiet ##1 !edge_m && edge_s && quiet
		|=> Q == $past(ns_vec, 2) && QN == ~$past(ns_vec, 2))
		else $error("slave did not take master value");

	ms_both_a: assert property (
		MASTER_SLAVE && both_act && CPV_TRUE == FBK_CPV_HIGH &&
		CPV_COMP == FBK_CPV_HIGH |=> Q == '1 && QN == '1)
		else $error("master-slave both-active wrong");

	comp_track_a: assert property (
		!MASTER_SLAVE && edge_m && quiet |=> QN == ~Q)
		else $error("complement not inverse of true");

	// a clock edge under clear is refused, clear wins
	edge_refused_a: assert property (
		edge_m && clr_act && !pre_act |=> Q == '0 && QN == '1)
		else $error("clock edge overrode clear");

	// feedback uses the true state only, checked from the pins
	jk_load_a: assert property (
		!MASTER_SLAVE && NS_MODE == FBK_NS_JK && !SYNC_CLR_EN && edge_m && quiet
		|=> Q == (($past(D) & ~$past(Q)) | (~$past(K) & $past(Q))))
		else $error("next value used wrong feedback");

	// the flag is sticky so a one-cycle both-active pulse is not lost
	unknown_flag_a: assert property (
		both_act && (CPV_TRUE == FBK_CPV_UNKNOWN || CPV_COMP == FBK_CPV_UNKNOWN)
		|=> UNKNOWN_SEEN)
		else $error("unknown setting not flagged");

	unknown_sticky_a: assert property (
		UNKNOWN_SEEN |=> UNKNOWN_SEEN)
		else $error("unknown flag dropped");

	// the setting rule checked both ways
	cfg_missing_a: assert property (
		CLR_EN && PRE_EN && CPV_TRUE == FBK_CPV_NONE && CPV_COMP == FBK_CPV_NONE
		|=> CFG_ERR)
		else $error("missing setting not flagged");

	cfg_clean_a: assert property (
		CLR_EN && PRE_EN && CPV_TRUE == FBK_CPV_LOW |=> !CFG_ERR)
		else $error("consistent setting flagged");

	// main scenarios to be reached

	cov_load_c: cover property (!MASTER_SLAVE && edge_m && quiet);
	cov_both_c: cover property (both_act ##1 quiet);
	cov_ms_c: cover property (MASTER_SLAVE && edge_m ##[1:4] edge_s);
	cov_jk_c: cover property (NS_MODE == FBK_NS_JK && edge_m && quiet);

endmodule : fbk_bank

`default_nettype wire

// File: verif/fbk_far.sv
// partner model: surrounding logic that makes the emulated cell clocks
`timescale 1ns/1ns
`default_nettype none

module fbk_far (
	// system
	input wire logic clk,
	// emulated cell clocks, idle low between pulses
	output logic cell_clk,
	output logic cell_clk_also
);
	// ------------------------------------------------------------
	// clock stepping
	// ------------------------------------------------------------
	initial begin
		cell_clk = 1'b0;
		cell_clk_also = 1'b0;
	end

	// each level held two cycles, though a level held for one cycle is already seen
	task automatic step_m(input logic v);
		cell_clk = v;
		repeat (2) @(posedge clk);
		#1;
	endtask : step_m

	task automatic step_s(input logic v);
		cell_clk_also = v;
		repeat (2) @(posedge clk);
		#1;
	endtask : step_s

	// full pulse; which step is the active edge depends on inversion
	task automatic pulse_m();
		step_m(1'b1);
		step_m(1'b0);
	endtask : pulse_m

	task automatic pulse_s();
		step_s(1'b1);
		step_s(1'b0);
	endtask : pulse_s

	// master edge, then the slave edge one cycle behind it
	task automatic pulse_ms();
		cell_clk = 1'b1;
		@(posedge clk);
		#1;
		cell_clk_also = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		cell_clk = 1'b0;
		cell_clk_also = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse_ms
endmodule : fbk_far

`default_nettype wire

// File: verif/fbk_bank_tb_top.sv
// testbench: self-checking sequences for the flop bank
`timescale 1ns/1ns
`default_nettype none

module fbk_bank_tb_top;
	import fbk_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, rst_n, clr_en, clr_hi, pre_en, pre_hi, ms, cinv, cainv, sclr_en;
	logic clr_in, pre_in, sclr, cfg_err, unk_seen, cc, cca;
	fbk_cpv_e cpv_t, cpv_c;
	fbk_ns_e ns;
	logic [3:0] d, k, q, qn, e;
	fbk_cpv_e tbl [4] = '{FBK_CPV_LOW, FBK_CPV_HIGH, FBK_CPV_HOLD, FBK_CPV_TOGGLE};
	logic [3:0] jt [4] = '{4'h3, 4'h0, 4'hf, 4'h5};
	logic [3:0] kt [4] = '{4'h0, 4'h0, 4'hf, 4'ha};
	int error_cnt = 0;
	int n_tests = 0;

	fbk_bank #(.WIDTH(4)) dut (.CLK(clk), .RST_N(rst_n), .CLR_EN(clr_en),
		.CLR_ACT_HIGH(clr_hi), .PRE_EN(pre_en), .PRE_ACT_HIGH(pre_hi),
		.CPV_TRUE(cpv_t), .CPV_COMP(cpv_c), .MASTER_SLAVE(ms), .CLK_INV(cinv),
		.CLK_ALSO_INV(cainv), .NS_MODE(ns), .SYNC_CLR_EN(sclr_en), .CELL_CLK(cc),
		.CELL_CLK_ALSO(cca), .CLR_IN(clr_in), .PRE_IN(pre_in), .SYNC_CLR(sclr),
		.D(d), .K(k), .Q(q), .QN(qn), .CFG_ERR(cfg_err), .UNKNOWN_SEEN(unk_seen));

	fbk_far far (.clk(clk), .cell_clk(cc), .cell_clk_also(cca));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] both_val(input fbk_cpv_e s, input logic [3:0] p);
		case (s)
			FBK_CPV_LOW: return 4'h0;
			FBK_CPV_HIGH: return 4'hf;
			FBK_CPV_TOGGLE: return ~p;
			default: return p;
		endcase
	endfunction : both_val

	task automatic chk(input string nm, input logic [3:0] ex, input logic [3:0] g);
		n_tests++;
		if (g !== ex) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk

	task automatic chkq(input logic [3:0] eq, input logic [3:0] eqn);
		chk("Q", eq, q);
		chk("QN", eqn, qn);
	endtask : chkq

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic load(input logic [3:0] v);
		d = v;
		far.pulse_m();
	endtask : load

	// both controls active for exactly one cycle, so toggle acts once
	task automatic both(input fbk_cpv_e t, input fbk_cpv_e c);
		cpv_t = t;
		cpv_c = c;
		tick(1);
		clr_in = 1'b1;
		pre_in = 1'b1;
		tick(1);
		clr_in = 1'b0;
		pre_in = 1'b0;
		tick(2);
	endtask : both

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{clr_en, clr_hi, pre_en, pre_hi} = 4'hf;
		{ms, cinv, cainv, sclr_en, clr_in, pre_in, sclr} = 7'h00;
		cpv_t = FBK_CPV_LOW;
		cpv_c = FBK_CPV_LOW;
		ns = FBK_NS_D;
		d = 4'h0;
		k = 4'h0;
		tick(8);
		rst_n = 1'b1;
		tick(1);
		chkq(4'h0, 4'hf);
		chk("CFG_ERR", 4'h0, {3'b000, cfg_err});
		chk("UNKNOWN_SEEN", 4'h0, {3'b000, unk_seen});
		load(4'ha);
		chkq(4'ha, 4'h5);
		load(4'h3);
		chkq(4'h3, 4'hc);
		// clear holds off a cell clock edge
		clr_in = 1'b1;
		tick(2);
		chkq(4'h0, 4'hf);
		load(4'h9);
		chkq(4'h0, 4'hf);
		clr_in = 1'b0;
		pre_in = 1'b1;
		tick(2);
		chkq(4'hf, 4'h0);
		pre_in = 1'b0;
		// active-low clear: level 0 now means clear
		clr_hi = 1'b0;
		clr_in = 1'b1;
		tick(1);
		clr_in = 1'b0;
		tick(2);
		chkq(4'h0, 4'hf);
		clr_hi = 1'b1;
		// active-low preset: level 0 now means preset
		pre_hi = 1'b0;
		pre_in = 1'b1;
		tick(1);
		pre_in = 1'b0;
		tick(2);
		chkq(4'hf, 4'h0);
		pre_hi = 1'b1;
		for (int i = 0; i < 4; i++) begin
			load(4'h6);
			both(tbl[i], tbl[3-i]);
			chkq(both_val(tbl[i], 4'h6), both_val(tbl[3-i], 4'h9));
		end
		both(FBK_CPV_UNKNOWN, FBK_CPV_HIGH);
		chkq(4'h0, 4'hf);
		chk("UNKNOWN_SEEN", 4'h1, {3'b000, unk_seen});
		cpv_t = FBK_CPV_NONE;
		cpv_c = FBK_CPV_NONE;
		tick(2);
		chk("CFG_ERR", 4'h1, {3'b000, cfg_err});
		cpv_t = FBK_CPV_LOW;
		pre_en = 1'b0;
		tick(2);
		chk("CFG_ERR", 4'h1, {3'b000, cfg_err});
		pre_en = 1'b1;
		tick(2);
		chk("CFG_ERR", 4'h0, {3'b000, cfg_err});
		// inverting the idle clock is no edge, since the history equals the level; still keep D equal to Q
		d = 4'h0;
		cinv = 1'b1;
		tick(2);
		d = 4'h5;
		far.step_m(1'b1);
		chkq(4'h0, 4'hf);
		far.step_m(1'b0);
		chkq(4'h5, 4'ha);
		cinv = 1'b0;
		sclr_en = 1'b1;
		sclr = 1'b1;
		d = 4'hf;
		tick(2);
		chkq(4'h5, 4'ha);
		far.pulse_m();
		chkq(4'h0, 4'hf);
		sclr = 1'b0;
		load(4'hc);
		chkq(4'hc, 4'h3);
		sclr_en = 1'b0;
		ns = FBK_NS_JK;
		e = 4'hc;
		for (int i = 0; i < 4; i++) begin
			d = jt[i];
			k = kt[i];
			far.pulse_m();
			e = (d & ~e) | (~k & e);
			chkq(e, ~e);
		end
		ns = FBK_NS_D;
		far.pulse_s();
		chkq(e, ~e);
		ms = 1'b1;
		tick(1);
		load(4'h7);
		chkq(e, ~e);
		far.pulse_s();
		chkq(4'h7, 4'h8);
		d = 4'h2;
		far.pulse_ms();
		chkq(4'h2, 4'hd);
		// falling slave edge: the rise must leave the visible state alone
		cainv = 1'b1;
		load(4'h4);
		chkq(4'h2, 4'hd);
		far.step_s(1'b1);
		chkq(4'h2, 4'hd);
		far.step_s(1'b0);
		chkq(4'h4, 4'hb);
		cainv = 1'b0;
		both(FBK_CPV_HIGH, FBK_CPV_HIGH);
		chkq(4'hf, 4'hf);
		far.pulse_s();
		chkq(4'hf, 4'hf);
		print_verdict();
	end

	// watchdog: the sequences need well under a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule : fbk_bank_tb_top

`default_nettype wire
